/* src/srf_pkg.sv */
// shared constants and types for the sar result formatter
package srf_pkg;
  // data widths
  localparam int DIFF_W  = 24;
  localparam int CM_W    = 8;
  localparam int RAW_W   = 25;
  localparam int CMRAW_W = 10;
  localparam int GAIN_W  = 16;
  localparam int WORD_W  = 32;
  localparam int FMT_W   = 3;
  localparam int LEN_W   = 6;
  localparam int CNT_W   = 8;
  // difference code limits and processing reset values
  localparam logic [DIFF_W-1:0] DIFF_MAX   = 24'h7FFFFF;
  localparam logic [DIFF_W-1:0] DIFF_MIN   = 24'h800000;
  localparam logic [DIFF_W-1:0] OFFSET_RST = 24'h000000;
  localparam logic [GAIN_W-1:0] GAIN_RST   = 16'h8000;
  localparam int                GAIN_SHIFT = 15;
  // raw difference clamp codes, 24-bit difference full scale sign-extended to the raw width
  localparam logic [RAW_W-1:0]  RAW_HI     = 25'h07FFFFF;
  localparam logic [RAW_W-1:0]  RAW_LO     = 25'h1800000;
  // common-mode code limits
  localparam logic [CM_W-1:0]   CM_MAX     = 8'hFF;
  localparam logic [CM_W-1:0]   CM_MIN     = 8'h00;
  // output format selections and word field layout
  localparam logic [FMT_W-1:0]  FMT_DIFF24 = 3'h0;
  localparam logic [FMT_W-1:0]  FMT_D16_CM = 3'h1;
  localparam logic [FMT_W-1:0]  FMT_D24_CM = 3'h2;
  localparam int                D16_LSB    = 8;
  localparam logic [LEN_W-1:0]  LEN_24     = 6'h18;
  localparam logic [LEN_W-1:0]  LEN_32     = 6'h20;
  localparam logic [WORD_W-1:0] WORD_RST   = 32'h00000000;
  // conversion timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int CONV_TIME_NS  = 300;
  localparam int CONV_CYC      = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // control states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_CONV = 3'h2,
    ST_PROC = 3'h4
  } srf_state_t;
endpackage

/* src/srf_proc.sv */
// offset, gain and 24-bit saturation of the difference code
`timescale 1ns/1ps
module srf_proc import srf_pkg::*; #(
  parameter int P_RAW_W  = RAW_W,
  parameter int P_DIFF_W = DIFF_W,
  parameter int P_GAIN_W = GAIN_W
) (
  input  wire logic signed [P_RAW_W-1:0]  raw_in,
  input  wire logic        [P_DIFF_W-1:0] offset_in,
  input  wire logic        [P_GAIN_W-1:0] gain_in,
  output logic             [P_DIFF_W-1:0] diff_out
);
  localparam int SUM_W  = P_RAW_W + 1;
  localparam int PROD_W = SUM_W + P_GAIN_W + 1;

  logic signed [SUM_W-1:0]    sum;
  logic signed [P_GAIN_W:0]   gain_s;
  logic signed [PROD_W-1:0]   prod;
  logic signed [PROD_W-1:0]   scaled;
  logic signed [PROD_W-1:0]   hi_lim;
  logic signed [PROD_W-1:0]   lo_lim;

  // offset add, then gain scaled by 1/0x8000, then clamp instead of wrap
  always_comb begin
    hi_lim = {{(PROD_W-P_DIFF_W){1'b0}}, DIFF_MAX};
    lo_lim = {{(PROD_W-P_DIFF_W){1'b1}}, DIFF_MIN};
    sum    = SUM_W'(raw_in) + SUM_W'($signed(offset_in));
    gain_s = $signed({1'b0, gain_in});
    prod   = PROD_W'(sum) * PROD_W'(gain_s);
    scaled = prod >>> GAIN_SHIFT;
    if (scaled > hi_lim) begin
      diff_out = DIFF_MAX;
    end else if (scaled < lo_lim) begin
      diff_out = DIFF_MIN;
    end else begin
      diff_out = scaled[P_DIFF_W-1:0];
    end
  end
endmodule // srf_proc

/* src/srf_top.sv */
// conversion control and result formatting of the sar converter
`timescale 1ns/1ps
module srf_top import srf_pkg::*; (
  input  wire logic                      clock_in,
  input  wire logic                      reset_n_in,
  input  wire logic                      convert_trigger_in,
  input  wire logic                      power_down_in,
  input  wire logic [FMT_W-1:0]          output_format_select_in,
  input  wire logic [DIFF_W-1:0]         offset_in,
  input  wire logic [GAIN_W-1:0]         gain_in,
  input  wire logic signed [RAW_W-1:0]   raw_diff_in,
  input  wire logic                      raw_overrange_in,
  input  wire logic signed [CMRAW_W-1:0] raw_cm_in,
  output logic                           busy_out,
  output logic                           sample_hold_out,
  output logic [WORD_W-1:0]              sample_word_out,
  output logic [LEN_W-1:0]               word_bits_out
);
  // convert pin synchroniser and filtered level
  logic                sync1_ff;
  logic                sync2_ff;
  logic                sync3_ff;
  logic                trig_lvl_ff;
  logic                nxt_trig_lvl;
  logic                trig_edge;
  // conversion control
  srf_state_t          state_ff;
  srf_state_t          nxt_state;
  logic [CNT_W-1:0]    cnt_ff;
  logic [CNT_W-1:0]    nxt_cnt;
  logic                busy_ff;
  logic                nxt_busy;
  logic                hold_ff;
  logic                nxt_hold;
  logic [FMT_W-1:0]    fmt_ff;
  logic [FMT_W-1:0]    nxt_fmt;
  logic [DIFF_W-1:0]   offset_ff;
  logic [DIFF_W-1:0]   nxt_offset;
  logic [GAIN_W-1:0]   gain_ff;
  logic [GAIN_W-1:0]   nxt_gain;
  logic [RAW_W-1:0]    raw_ff;
  logic [RAW_W-1:0]    nxt_raw;
  logic [CM_W-1:0]     cm_ff;
  logic [CM_W-1:0]     nxt_cm;
  logic [WORD_W-1:0]   word_ff;
  logic [WORD_W-1:0]   nxt_word;
  logic [LEN_W-1:0]    len_ff;
  logic [LEN_W-1:0]    nxt_len;
  logic [DIFF_W-1:0]   proc_diff;
  logic                start;
  logic                capture;

  // three-stage synchroniser, level changes once stages two and three agree
  always_comb begin
    nxt_trig_lvl = trig_lvl_ff;
    if (sync2_ff == sync3_ff) begin
      nxt_trig_lvl = sync3_ff;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      sync1_ff    <= 1'b0;
      sync2_ff    <= 1'b0;
      sync3_ff    <= 1'b0;
      trig_lvl_ff <= 1'b0;
    end else begin
      sync1_ff    <= convert_trigger_in;
      sync2_ff    <= sync1_ff;
      sync3_ff    <= sync2_ff;
      trig_lvl_ff <= nxt_trig_lvl;
    end
  end

  assign trig_edge = (sync2_ff == sync3_ff) && sync3_ff && !trig_lvl_ff;
  // no dummy cycle after power-down, any idle edge starts unless power-down is high
  assign start     = (state_ff == ST_IDLE) && trig_edge && !power_down_in;
  assign capture   = (state_ff == ST_CONV) && (cnt_ff == '0);

  // difference processing on the captured raw code
  srf_proc #(
    .P_RAW_W  (RAW_W),
    .P_DIFF_W (DIFF_W),
    .P_GAIN_W (GAIN_W)
  ) i_srf_proc (
    .raw_in    ($signed(raw_ff)),
    .offset_in (offset_ff),
    .gain_in   (gain_ff),
    .diff_out  (proc_diff)
  );

  // conversion sequence, capture, format and output latch
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_busy   = busy_ff;
    nxt_hold   = 1'b0;
    nxt_fmt    = fmt_ff;
    nxt_offset = offset_ff;
    nxt_gain   = gain_ff;
    nxt_raw    = raw_ff;
    nxt_cm     = cm_ff;
    nxt_word   = word_ff;
    nxt_len    = len_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (start) begin
          // busy and sample on the edge
          nxt_state  = ST_CONV;
          nxt_busy   = 1'b1;
          nxt_hold   = 1'b1;
          nxt_cnt    = CNT_W'(CONV_CYC - 1);
          nxt_fmt    = output_format_select_in;
          nxt_offset = offset_in;
          nxt_gain   = gain_in;
        end
      end
      ST_CONV: begin
        if (capture) begin
          nxt_state = ST_PROC;
          if (raw_overrange_in) begin
            nxt_raw = raw_diff_in[RAW_W-1] ? RAW_LO : RAW_HI;
          end else begin
            nxt_raw = raw_diff_in;
          end
          if (raw_cm_in < 0) begin
            nxt_cm = CM_MIN;
          end else if (raw_cm_in > $signed({2'b00, CM_MAX})) begin
            nxt_cm = CM_MAX;
          end else begin
            nxt_cm = raw_cm_in[CM_W-1:0];
          end
        end else begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
      end
      ST_PROC: begin
        // latch processed word, busy drops with it
        nxt_state = ST_IDLE;
        nxt_busy  = 1'b0;
        // common-mode byte bypasses offset and gain
        case (fmt_ff)
          FMT_D16_CM: begin
            nxt_word = {8'h00, proc_diff[DIFF_W-1:D16_LSB], cm_ff};
            nxt_len  = LEN_24;
          end
          FMT_D24_CM: begin
            nxt_word = {proc_diff, cm_ff};
            nxt_len  = LEN_32;
          end
          default: begin
            nxt_word = {8'h00, proc_diff};
            nxt_len  = LEN_24;
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      state_ff  <= ST_IDLE;
      cnt_ff    <= '0;
      busy_ff   <= 1'b0;
      hold_ff   <= 1'b0;
      fmt_ff    <= FMT_DIFF24;
      offset_ff <= OFFSET_RST;
      gain_ff   <= GAIN_RST;
      raw_ff    <= '0;
      cm_ff     <= CM_MIN;
      word_ff   <= WORD_RST;
      len_ff    <= LEN_24;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      busy_ff   <= nxt_busy;
      hold_ff   <= nxt_hold;
      fmt_ff    <= nxt_fmt;
      offset_ff <= nxt_offset;
      gain_ff   <= nxt_gain;
      raw_ff    <= nxt_raw;
      cm_ff     <= nxt_cm;
      word_ff   <= nxt_word;
      len_ff    <= nxt_len;
    end
  end

  // outputs straight from registers
  assign busy_out        = busy_ff;
  assign sample_hold_out = hold_ff;
  assign sample_word_out = word_ff;
  assign word_bits_out   = len_ff;

  // checking helpers: length of the current busy stretch
  logic [CNT_W-1:0] busy_len_ff;
  always_ff @(posedge clock_in) begin
    if (!reset_n_in || !busy_ff) begin
      busy_len_ff <= '0;
    end else begin
      busy_len_ff <= busy_len_ff + CNT_W'(1);
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_start;
    start;
  endsequence
  sequence s_sample;
    busy_out && sample_hold_out ##1 busy_out && !sample_hold_out;
  endsequence
  sequence s_proc;
    state_ff == ST_PROC;
  endsequence

  busy_rise_a: assert property (s_start |=> s_sample)
    else $error("busy or sample missing after convert edge");
  busy_fall_a: assert property ($fell(busy_out) |-> $past(busy_len_ff) == CNT_W'(CONV_CYC))
    else $error("busy stretch has wrong length");
  word_latch_a: assert property ($fell(busy_out) |-> $past(state_ff) == ST_PROC)
    else $error("busy fell without a latched result");
  raw_clamp_a: assert property (capture && raw_overrange_in |=>
                               (raw_ff == RAW_HI || raw_ff == RAW_LO))
    else $error("overrange raw code not clamped");
  cm_clamp_a: assert property (capture && raw_cm_in > 10'sh0FF |=> cm_ff == CM_MAX)
    else $error("common-mode code not clamped high");
  diff_sat_a: assert property (s_proc and (offset_ff == OFFSET_RST) and (gain_ff >= GAIN_RST)
                              and !raw_ff[RAW_W-1] and (raw_ff >= RAW_HI)
                              |-> proc_diff == DIFF_MAX)
    else $error("difference not saturated at top");
  unity_path_a: assert property (s_proc and (offset_ff == OFFSET_RST) and (gain_ff == GAIN_RST)
                                and (raw_ff[RAW_W-1] == raw_ff[DIFF_W-1])
                                |-> proc_diff == raw_ff[DIFF_W-1:0])
    else $error("default offset and gain alter the code");
  fmt_cm_a: assert property (s_proc and fmt_ff == FMT_D24_CM |=>
                            sample_word_out == {$past(proc_diff), $past(cm_ff)})
    else $error("24-bit plus common-mode word wrong");
  fmt_d16_a: assert property (s_proc and fmt_ff == FMT_D16_CM |=>
                             sample_word_out[DIFF_W-1:D16_LSB] ==
                             $past(proc_diff[DIFF_W-1:D16_LSB])
                             && sample_word_out[CM_W-1:0] == $past(cm_ff))
    else $error("16-bit plus common-mode word wrong");
  fmt_bare_a: assert property (s_proc and fmt_ff == FMT_DIFF24 |=>
                              sample_word_out == {8'h00, $past(proc_diff)})
    else $error("bare difference word wrong");

  // further guards on clamps, hold pulse, word stability and timing
  localparam int CAPTURE_DLY = CONV_CYC;

  cm_low_a: assert property (capture && raw_cm_in < 0 |=> cm_ff == CM_MIN)
    else $error("common-mode code not clamped low");
  cm_pass_a: assert property (capture && raw_cm_in >= 0 && raw_cm_in <= 10'sh0FF |=>
                             cm_ff == $past(raw_cm_in[CM_W-1:0]))
    else $error("in-range common-mode code altered");
  hold_pulse_a: assert property (sample_hold_out |=> !sample_hold_out)
    else $error("sample hold longer than one cycle");
  pd_block_a: assert property (power_down_in && state_ff == ST_IDLE |=>
                              state_ff == ST_IDLE)
    else $error("conversion started during power-down");
  capture_time_a: assert property (s_start |-> ##[CAPTURE_DLY:CAPTURE_DLY] capture)
    else $error("raw codes not captured on time");
  result_ready_a: assert property (capture |=> s_proc ##1 !busy_out)
    else $error("busy did not drop after capture");
  busy_idle_a: assert property (state_ff == ST_IDLE |-> !busy_out)
    else $error("busy high while idle");
  word_stable_a: assert property (state_ff != ST_PROC |=>
                                 $stable(sample_word_out) && $stable(word_bits_out))
    else $error("output word changed outside a latch");
  len_bits_a: assert property (s_proc |=> word_bits_out ==
                              (($past(fmt_ff) == FMT_D24_CM) ? LEN_32 : LEN_24))
    else $error("word length does not match format");
  diff_low_a: assert property (s_proc and (offset_ff == OFFSET_RST) and (gain_ff >= GAIN_RST)
                              and raw_ff[RAW_W-1] and (raw_ff <= RAW_LO)
                              |-> proc_diff == DIFF_MIN)
    else $error("difference not saturated at bottom");
endmodule // srf_top

/* tb/srf_host_model.sv */
// host controller model that issues convert edges and reads sample words
`timescale 1ns/1ps
module srf_host_model import srf_pkg::*; (
  input  wire logic              clock_in,
  input  wire logic              busy_in,
  input  wire logic              hold_in,
  input  wire logic [WORD_W-1:0] word_in,
  output logic                   convert_trigger_out
);
  initial convert_trigger_out = 1'b0;
  // one rising edge per sample
  // raise the pin, drop it once busy shows, then wait for busy to fall
  task automatic convert(input int lim, output logic [WORD_W-1:0] w,
                         output int bc, output int hc, output bit to);
    int n;
    n = 0;
    hc = 0;
    @(posedge clock_in);
    convert_trigger_out <= 1'b1;
    do begin
      @(posedge clock_in);
      #1;
      n++;
      hc += int'(hold_in === 1'b1);
    end while (busy_in !== 1'b1 && n < lim);
    to = (busy_in !== 1'b1);
    bc = int'(!to);
    n = 0;
    do begin
      @(posedge clock_in);
      convert_trigger_out <= 1'b0;
      #1;
      n++;
      bc += int'(busy_in === 1'b1);
      hc += int'(hold_in === 1'b1);
    end while (busy_in === 1'b1 && n < 200);
    to |= (busy_in === 1'b1);
    w = word_in;
  endtask
endmodule // srf_host_model

/* tb/sar_result_formatter_bench.sv */
// self-checking bench of the result formatter driven by a host model
`timescale 1ns/1ps
module sar_result_formatter_bench import srf_pkg::*;;
  logic                      clock_in;
  logic                      reset_n_in;
  logic                      trig;
  logic                      pd;
  logic [FMT_W-1:0]          fmt;
  logic [DIFF_W-1:0]         ofs;
  logic [GAIN_W-1:0]         gain;
  logic signed [RAW_W-1:0]   raw;
  logic                      ovr;
  logic signed [CMRAW_W-1:0] cm;
  logic                      busy;
  logic                      hold;
  logic [WORD_W-1:0]         word;
  logic [LEN_W-1:0]          bits;
  int                        bad_count;
  int                        total_checks;

  srf_top i_srf_top (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .convert_trigger_in(trig),
    .power_down_in(pd), .output_format_select_in(fmt), .offset_in(ofs), .gain_in(gain),
    .raw_diff_in(raw), .raw_overrange_in(ovr), .raw_cm_in(cm), .busy_out(busy),
    .sample_hold_out(hold), .sample_word_out(word), .word_bits_out(bits)
  );
  srf_host_model i_srf_host_model (
    .clock_in(clock_in), .busy_in(busy), .hold_in(hold), .word_in(word),
    .convert_trigger_out(trig)
  );

  // free-running system clock
  initial begin
    clock_in = 1'b0;
    forever #(CLK_PERIOD_NS / 2.0) clock_in = ~clock_in;
  end

  // compare one value and count it
  task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // print the counts and the verdict, then stop
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one conversion with the given setup, judged on word, length, busy and hold
  task automatic one(input logic [FMT_W-1:0] f, input logic [DIFF_W-1:0] o,
                     input logic [GAIN_W-1:0] g, input logic [RAW_W-1:0] r, input logic v,
                     input logic [CMRAW_W-1:0] c, input logic [WORD_W-1:0] ew);
    logic [WORD_W-1:0] w;
    int                bc;
    int                hc;
    bit                to;
    @(posedge clock_in);
    fmt <= f;
    ofs <= o;
    gain <= g;
    raw <= r;
    ovr <= v;
    cm <= c;
    i_srf_host_model.convert(100, w, bc, hc, to);
    if (to) begin
      bad_count++;
      print_verdict();
    end
    check(w, ew);
    check(bits, (f == FMT_D24_CM) ? LEN_32 : LEN_24);
    check(bc, CONV_CYC + 1);
    check(hc, 1);
  endtask

  // default path codes, back to back, first one right after reset
  task automatic test_codes();
    logic [RAW_W-1:0] codes [6] = '{25'h123, 25'h7FFFFF, 25'h0, 25'h1FFFFFF,
                                    25'h1800001, 25'h1800000};
    foreach (codes[i]) begin
      one(3'h0, 24'h0, 16'h8000, codes[i], 1'b0, 10'h40, {8'h00, codes[i][23:0]});
    end
    $display("test codes done");
  endtask

  // overrange clamps before offset; offset, gain and saturation
  task automatic test_processing();
    one(3'h0, 24'h0, 16'h8000, 25'h5, 1'b1, 10'h40, 32'h7FFFFF);
    one(3'h0, 24'h0, 16'h8000, 25'h1FFFFF0, 1'b1, 10'h40, 32'h800000);
    one(3'h0, 24'hFFFFFF, 16'h8000, 25'h5, 1'b1, 10'h40, 32'h7FFFFE);
    one(3'h0, 24'h10, 16'h4000, 25'h100, 1'b0, 10'h40, 32'h88);
    one(3'h0, 24'h1, 16'h8000, 25'h7FFFFF, 1'b0, 10'h40, 32'h7FFFFF);
    one(3'h0, 24'h0, 16'hFFFF, 25'h600000, 1'b0, 10'h40, 32'h7FFFFF);
    one(3'h0, 24'h0, 16'hFFFF, 25'h1A00000, 1'b0, 10'h40, 32'h800000);
    one(3'h0, 24'h0, 16'h4000, 25'h1FFFFFD, 1'b0, 10'h40, 32'hFFFFFE);
    one(3'h0, 24'h0, 16'h7E00, 25'h820000, 1'b0, 10'h40, 32'h7FF800);
    $display("test processing done");
  endtask

  // output formats and the common-mode byte
  task automatic test_formats();
    one(3'h1, 24'h0, 16'h8000, 25'h123456, 1'b0, 10'h5A, 32'h12345A);
    one(3'h2, 24'h0, 16'h8000, 25'h123456, 1'b0, 10'h5A, 32'h1234565A);
    one(3'h3, 24'h0, 16'h8000, 25'h123456, 1'b0, 10'h5A, 32'h123456);
    one(3'h7, 24'h0, 16'h8000, 25'h123456, 1'b0, 10'h5A, 32'h123456);
    one(3'h2, 24'h0, 16'h8000, 25'h0, 1'b0, 10'h3FB, 32'h0);
    one(3'h2, 24'h0, 16'h8000, 25'h0, 1'b0, 10'h12C, 32'hFF);
    one(3'h2, 24'h10, 16'h4000, 25'h100, 1'b0, 10'h5A, 32'h885A);
    one(3'h1, 24'h0, 16'h4000, 25'h123456, 1'b0, 10'h5A, 32'h91A5A);
    $display("test formats done");
  endtask

  // edges ignored in power-down, first conversion after it is valid
  task automatic test_power_down();
    logic [WORD_W-1:0] w;
    int                bc;
    int                hc;
    bit                to;
    @(posedge clock_in);
    pd <= 1'b1;
    i_srf_host_model.convert(12, w, bc, hc, to);
    check(bc, 0);
    check(to, 1'b1);
    repeat (4) @(posedge clock_in);
    pd <= 1'b0;
    one(3'h0, 24'h0, 16'h8000, 25'h42, 1'b0, 10'h40, 32'h42);
    $display("test power down done");
  endtask

  // reset, then the scenarios in turn
  initial begin
    reset_n_in = 1'b0;
    pd = 1'b0;
    fmt = FMT_DIFF24;
    ofs = OFFSET_RST;
    gain = GAIN_RST;
    raw = '0;
    ovr = 1'b0;
    cm = '0;
    bad_count = 0;
    total_checks = 0;
    repeat (8) @(posedge clock_in);
    reset_n_in <= 1'b1;
    #1;
    check(busy, 1'b0);
    check(bits, LEN_24);
    test_codes();
    test_processing();
    test_formats();
    test_power_down();
    print_verdict();
  end
endmodule // sar_result_formatter_bench
